// *** inc/usbsf_pkg.sv ***
package usbsf_pkg;

   // Register byte offsets.
   localparam logic [7:0] OFS_FRAME_STATUS  = 8'h00;
   localparam logic [7:0] OFS_DEVICE_STATE  = 8'h04;
   localparam logic [7:0] OFS_FUNC_ADDRESS  = 8'h08;
   localparam logic [7:0] OFS_IRQ_ENABLE    = 8'h10;
   localparam logic [7:0] OFS_IRQ_DISABLE   = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK      = 8'h18;

   // Frame status fields.
   localparam int FRAME_W          = 11;
   localparam int BIT_FRAME_ERROR  = 16;
   localparam int BIT_FRAME_VALID  = 17;

   // Byte-wide frame view fields.
   localparam int BYTE_BIT_VALID   = 4;
   localparam int BYTE_BIT_ERROR   = 3;

   // Device state fields.
   localparam int BIT_ADDR_STATE   = 0;
   localparam int BIT_CONFIGURED   = 1;

   // Function address fields.
   localparam int FADDR_W          = 7;
   localparam int BIT_FUNC_ENABLE  = 8;
   localparam logic [6:0] FADDR_RESET  = 7'h00;
   localparam logic       FEN_RESET    = 1'b1;

   // Interrupt mask layout.
   localparam int MASK_W           = 16;
   localparam logic [15:0] MASK_WRITABLE = 16'h2b0f;
   localparam logic [15:0] MASK_FIXED    = 16'h1000;
   localparam logic [15:0] MASK_RESET    = 16'h0200;

   // Start-of-frame events from the serial engine.
   typedef struct packed {
      logic        identifier;
      logic        packet_end;
      logic        crc_error;
      logic [10:0] index;
   } usbsf_sof_t;

   // Avalon-MM request from the master.
   typedef struct packed {
      logic        read;
      logic        write;
      logic [7:0]  address;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } usbsf_req_t;

endpackage

// *** design/usbsf_regs.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Eleven-bit frame index loads from each start-of-frame packet at its end.
// - Frame error flag sets at packet end when the packet had an error.
// - Frame valid flag sets at packet end when the packet was error free.
// - Both frame flags clear when a start-of-frame identifier arrives.
// - Start-of-frame interrupt status rises on the identifier, not at packet end.
// - Byte view: valid flag is high byte bit 4, error is low byte bit 3.
// - Address-state bit reads one only while the device is addressed.
// - Writing zero to address-state does nothing; only reset leaves it.
// - Writing one to address-state enters the addressed state.
// - Configured bit reads state; write one enters, write zero leaves.
// - Seven-bit function address resets to zero.
// - Function enable reads back; write zero disables, write one enables.
// - Enable port ones at endpoint bits 0..3 set mask bits; zeros ignored.
// - Disable port ones at endpoint bits 0..3 clear mask bits; zeros ignored.
// - Enable port bits 8, 9, 11, 13 enable suspend, resume, frame, wakeup.
// - Mask register reads one for every currently enabled source.
// - Disable port bits 8, 9, 11, 13 clear those event mask bits.
module usbsf_regs
   import usbsf_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input  wire logic              sys_clk_i,
   input  wire logic              reset_i,
   input  wire logic              bus_reset_i,
   input  wire usbsf_sof_t        sof_i,
   input  wire usbsf_req_t        avm_i,
   output logic                   avm_waitrequest_o,
   output logic [31:0]            avm_readdata_o,
   output logic [FRAME_W-1:0]     frame_index_o,
   output logic                   frame_valid_flag_o,
   output logic                   frame_error_flag_o,
   output logic [7:0]             frame_index_low_byte_o,
   output logic [7:0]             frame_index_high_byte_o,
   output logic                   frame_start_irq_o,
   output logic                   address_state_o,
   output logic                   configured_o,
   output logic [FADDR_W-1:0]     function_address_o,
   output logic                   function_endpoint_enable_o,
   output logic [MASK_W-1:0]      irq_mask_o
);

   if (ADDR_W != 8)
   begin : g_check
      $error("Register decode serves an eight-bit byte address only.");
   end

   // Expands byte enables into a bit mask.
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++)
      begin
         m[i*8 +: 8] = {8{be[i]}};
      end
      return m;
   endfunction

   // Builds the byte-wide frame view from the index and flags.
   function automatic logic [15:0] byte_view(input logic [10:0] idx,
                                             input logic        ok,
                                             input logic        err);
      logic [15:0] v;
      v = {5'h00, idx};
      v[8 + BYTE_BIT_VALID] = ok;
      v[BYTE_BIT_ERROR] = err;
      return v;
   endfunction

   logic                 wait_q;
   logic [31:0]          rdata_q;
   logic [31:0]          rdata_d;
   logic                 req;
   logic                 acc;
   logic [31:0]          wbits;
   logic                 wr_state;
   logic                 wr_faddr;
   logic                 wr_ien;
   logic                 wr_idis;
   logic [FRAME_W-1:0]   frame_q;
   logic                 ok_q;
   logic                 err_q;
   logic                 ok_d;
   logic                 err_d;
   logic [FRAME_W-1:0]   frame_d;
   logic [15:0]          bview_d;
   logic                 sof_irq_q;
   logic                 addr_q;
   logic                 cfg_q;
   logic [FADDR_W-1:0]   function_address_value_q;
   logic                 fen_q;
   logic [MASK_W-1:0]    mask_q;

   assign req      = avm_i.read | avm_i.write;
   assign acc      = req & ~wait_q;
   assign wbits    = avm_i.writedata & lane_mask(avm_i.byteenable);
   assign wr_state = acc & avm_i.write
                     & (avm_i.address == OFS_DEVICE_STATE);
   assign wr_faddr = acc & avm_i.write
                     & (avm_i.address == OFS_FUNC_ADDRESS);
   assign wr_ien   = acc & avm_i.write
                     & (avm_i.address == OFS_IRQ_ENABLE);
   assign wr_idis  = acc & avm_i.write
                     & (avm_i.address == OFS_IRQ_DISABLE);

   // Read multiplexer; unmapped and write-only offsets read zero.
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      case (avm_i.address)
         OFS_FRAME_STATUS:
         begin
            rdata_d[FRAME_W-1:0]    = frame_q;
            rdata_d[BIT_FRAME_ERROR] = err_q;
            rdata_d[BIT_FRAME_VALID] = ok_q;
         end
         OFS_DEVICE_STATE:
         begin
            rdata_d[BIT_ADDR_STATE] = addr_q;
            rdata_d[BIT_CONFIGURED] = cfg_q;
         end
         OFS_FUNC_ADDRESS:
         begin
            rdata_d[FADDR_W-1:0]     = function_address_value_q;
            rdata_d[BIT_FUNC_ENABLE] = fen_q;
         end
         OFS_IRQ_MASK:
         begin
            rdata_d[MASK_W-1:0] = mask_q;
         end
         default:
         begin
            rdata_d = 32'h0000_0000;
         end
      endcase
   end

   // Bus handshake: one wait cycle, then a single accepting cycle.
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end
      else if (req && wait_q)
      begin
         wait_q  <= 1'b0;
         rdata_q <= rdata_d;
      end
      else
      begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end
   end

   // Frame flags: the end-of-packet set wins over an identifier clear.
   always_comb
   begin
      frame_d = frame_q;
      ok_d    = ok_q;
      err_d   = err_q;
      if (sof_i.identifier)
      begin
         ok_d  = 1'b0;
         err_d = 1'b0;
      end
      if (sof_i.packet_end)
      begin
         frame_d = sof_i.index;
         if (sof_i.crc_error)
         begin
            err_d = 1'b1;
         end
         else
         begin
            ok_d = 1'b1;
         end
      end
      bview_d = byte_view(frame_d, ok_d, err_d);
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         frame_q                 <= '0;
         ok_q                    <= 1'b0;
         err_q                   <= 1'b0;
         frame_index_low_byte_o  <= 8'h00;
         frame_index_high_byte_o <= 8'h00;
      end
      else
      begin
         frame_q                 <= frame_d;
         ok_q                    <= ok_d;
         err_q                   <= err_d;
         frame_index_low_byte_o  <= bview_d[7:0];
         frame_index_high_byte_o <= bview_d[15:8];
      end
   end

   // Start-of-frame event is flagged as soon as the identifier is seen.
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         sof_irq_q <= 1'b0;
      end
      else
      begin
         sof_irq_q <= sof_i.identifier;
      end
   end

   // Device state: address state leaves only through a reset.
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i || bus_reset_i)
      begin
         addr_q <= 1'b0;
         cfg_q  <= 1'b0;
      end
      else if (wr_state && avm_i.byteenable[0])
      begin
         if (wbits[BIT_ADDR_STATE])
         begin
            addr_q <= 1'b1;
         end
         cfg_q <= wbits[BIT_CONFIGURED];
      end
   end

   // Function address and enable.
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         function_address_value_q <= FADDR_RESET;
         fen_q  <= FEN_RESET;
      end
      else if (wr_faddr)
      begin
         if (avm_i.byteenable[0])
         begin
            function_address_value_q <= wbits[FADDR_W-1:0];
         end
         if (avm_i.byteenable[1])
         begin
            fen_q <= wbits[BIT_FUNC_ENABLE];
         end
      end
   end

   // Interrupt mask: set and clear ports touch only bits written as one.
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i || bus_reset_i)
      begin
         mask_q <= MASK_RESET | MASK_FIXED;
      end
      else if (wr_ien)
      begin
         mask_q <= mask_q | (wbits[MASK_W-1:0] & MASK_WRITABLE);
      end
      else if (wr_idis)
      begin
         mask_q <= mask_q & ~(wbits[MASK_W-1:0] & MASK_WRITABLE);
      end
   end

   assign avm_waitrequest_o          = wait_q;
   assign avm_readdata_o             = rdata_q;
   assign frame_index_o              = frame_q;
   assign frame_valid_flag_o         = ok_q;
   assign frame_error_flag_o         = err_q;
   assign frame_start_irq_o          = sof_irq_q;
   assign address_state_o            = addr_q;
   assign configured_o               = cfg_q;
   assign function_address_o         = function_address_value_q;
   assign function_endpoint_enable_o = fen_q;
   assign irq_mask_o                 = mask_q;

   a_frame_load: assert property (@(posedge sys_clk_i)
      disable iff (reset_i)
      sof_i.packet_end |=> frame_index_o == $past(sof_i.index))
      else $error("Frame index not loaded at packet end.");

   a_frame_hold: assert property (@(posedge sys_clk_i)
      disable iff (reset_i)
      !sof_i.packet_end |=> $stable(frame_index_o))
      else $error("Frame index changed without a packet end.");

   a_frame_err_set: assert property (@(posedge sys_clk_i)
      disable iff (reset_i)
      sof_i.packet_end && sof_i.crc_error
      |=> frame_error_flag_o && !frame_valid_flag_o)
      else $error("Frame error flag not set on bad packet.");

   a_frame_ok_set: assert property (@(posedge sys_clk_i)
      disable iff (reset_i)
      sof_i.packet_end && !sof_i.crc_error
      |=> frame_valid_flag_o && !frame_error_flag_o)
      else $error("Frame valid flag not set on good packet.");

   a_frame_pid_clear: assert property (@(posedge sys_clk_i)
      disable iff (reset_i)
      sof_i.identifier && !sof_i.packet_end
      |=> !frame_valid_flag_o && !frame_error_flag_o)
      else $error("Frame flags not cleared by identifier.");

   a_sof_irq_early: assert property (@(posedge sys_clk_i)
      disable iff (reset_i)
      $rose(sof_i.identifier) |=> frame_start_irq_o ##1 !frame_start_irq_o
      || $past(sof_i.identifier, 1))
      else $error("Start-of-frame event not raised on identifier.");

   a_byte_view: assert property (@(posedge sys_clk_i)
      disable iff (reset_i)
      frame_index_high_byte_o[BYTE_BIT_VALID] == frame_valid_flag_o
      && frame_index_low_byte_o[BYTE_BIT_ERROR] == frame_error_flag_o)
      else $error("Byte view flag positions wrong.");

   a_addr_sticky: assert property (@(posedge sys_clk_i)
      disable iff (reset_i)
      address_state_o && !bus_reset_i |=> address_state_o)
      else $error("Address state left without reset.");

   a_addr_enter: assert property (@(posedge sys_clk_i)
      disable iff (reset_i)
      wr_state && wbits[BIT_ADDR_STATE] && !bus_reset_i
      |=> address_state_o ##1 address_state_o || $past(bus_reset_i))
      else $error("Address state not entered on write.");

   a_cfg_write: assert property (@(posedge sys_clk_i)
      disable iff (reset_i)
      wr_state && avm_i.byteenable[0] && !bus_reset_i
      |=> configured_o == $past(wbits[BIT_CONFIGURED]))
      else $error("Configured state did not follow the write.");

   a_fen_write: assert property (@(posedge sys_clk_i)
      disable iff (reset_i)
      wr_faddr && avm_i.byteenable[1]
      |=> function_endpoint_enable_o == $past(wbits[BIT_FUNC_ENABLE]))
      else $error("Function enable did not follow the write.");

   a_mask_keep: assert property (@(posedge sys_clk_i)
      disable iff (reset_i)
      wr_idis && !bus_reset_i
      |=> (irq_mask_o & ~$past(wbits[MASK_W-1:0]))
          == ($past(irq_mask_o) & ~$past(wbits[MASK_W-1:0])))
      else $error("Disable port changed bits written as zero.");

   a_mask_enable: assert property (@(posedge sys_clk_i)
      disable iff (reset_i)
      wr_ien && !bus_reset_i
      |=> ((irq_mask_o & $past(wbits[MASK_W-1:0]) & MASK_WRITABLE)
          == ($past(wbits[MASK_W-1:0]) & MASK_WRITABLE))
          && ((irq_mask_o & ~$past(wbits[MASK_W-1:0]))
          == ($past(irq_mask_o) & ~$past(wbits[MASK_W-1:0]))))
      else $error("Enable port did not set exactly the written bits.");

   a_mask_disable: assert property (@(posedge sys_clk_i)
      disable iff (reset_i)
      wr_idis && !bus_reset_i
      |=> ((irq_mask_o & $past(wbits[MASK_W-1:0]) & MASK_WRITABLE) == 16'h0000)
          && irq_mask_o[12])
      else $error("Disable port did not clear the written bits.");

endmodule // usbsf_regs

// *** dv/usbsf_host_model.sv ***
`timescale 1ns/1ps
module usbsf_host_model
   import usbsf_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        send_i,
   input  wire logic [10:0] index_i,
   input  wire logic        err_i,
   output usbsf_sof_t       sof_o
);
   logic [2:0] step_q;
   initial
   begin
      step_q = 3'h0;
      sof_o  = '0;
   end
   // Identifier first, end of packet four cycles later; idle lines toggle.
   always @(posedge sys_clk_i)
   begin
      sof_o.identifier <= 1'b0;
      sof_o.packet_end <= 1'b0;
      sof_o.index      <= ~sof_o.index;
      sof_o.crc_error  <= ~sof_o.crc_error;
      if (step_q == 3'h4)
      begin
         sof_o.packet_end <= 1'b1;
         sof_o.index      <= index_i;
         sof_o.crc_error  <= err_i;
         step_q           <= 3'h0;
      end
      else if (step_q != 3'h0)
         step_q <= step_q + 3'h1;
      else if (send_i)
      begin
         sof_o.identifier <= 1'b1;
         step_q           <= 3'h1;
      end
   end
endmodule // usbsf_host_model

// *** dv/usbsf_regs_test.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
fail_count++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module usbsf_regs_test
   import usbsf_pkg::*;
;
   logic        clk, rst, brst, send, err;
   logic [10:0] idx, frame;
   usbsf_sof_t  sof;
   usbsf_req_t  req;
   logic        wt, fval, ferr, firq, ast, cfg, function_endpoint_enable;
   logic [31:0] rd;
   logic [7:0]  lo, hi;
   logic [6:0]  fad;
   logic [15:0] mask;
   int          fail_count;
   int          checks_done;

   usbsf_host_model usbsf_host_model_i (.sys_clk_i(clk), .send_i(send),
      .index_i(idx), .err_i(err), .sof_o(sof));
   usbsf_regs #(.ADDR_W(8)) usbsf_regs_i (.sys_clk_i(clk), .reset_i(rst),
      .bus_reset_i(brst), .sof_i(sof), .avm_i(req),
      .avm_waitrequest_o(wt), .avm_readdata_o(rd), .frame_index_o(frame),
      .frame_valid_flag_o(fval), .frame_error_flag_o(ferr),
      .frame_index_low_byte_o(lo), .frame_index_high_byte_o(hi),
      .frame_start_irq_o(firq), .address_state_o(ast), .configured_o(cfg),
      .function_address_o(fad), .function_endpoint_enable_o(function_endpoint_enable),
      .irq_mask_o(mask));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk);
      req.read      <= ~w;
      req.write     <= w;
      req.address   <= a;
      req.writedata <= d;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wt !== 1'b0 && n < 20);
      q = rd;
      req.read  <= 1'b0;
      req.write <= 1'b0;
      if (n >= 20)
         fail_count++;
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      `CHK("readdata", e, q)
   endtask

   task automatic t_reset;
      `CHK("mask", 16'h1200, mask)
      rdc(OFS_FRAME_STATUS, 32'h0);
      rdc(OFS_DEVICE_STATE, 32'h0);
      rdc(OFS_FUNC_ADDRESS, 32'h100);
      rdc(OFS_IRQ_MASK, 32'h1200);
      rdc(8'h0c, 32'h0);
      rdc(OFS_IRQ_ENABLE, 32'h0);
      wr(OFS_FRAME_STATUS, 32'hffff_ffff);
      rdc(OFS_FRAME_STATUS, 32'h0);
   endtask

   task automatic t_mask;
      wr(OFS_IRQ_ENABLE, 32'h0);
      `CHK("mask", 16'h1200, mask)
      wr(OFS_IRQ_ENABLE, 32'hffff_ffff);
      `CHK("mask", 16'h3b0f, mask)
      rdc(OFS_IRQ_MASK, 32'h3b0f);
      wr(OFS_IRQ_DISABLE, 32'h5);
      `CHK("mask", 16'h3b0a, mask)
      wr(OFS_IRQ_DISABLE, 32'h2a00);
      `CHK("mask", 16'h110a, mask)
      wr(OFS_IRQ_ENABLE, 32'h0a00);
      `CHK("mask", 16'h1b0a, mask)
      wr(OFS_IRQ_DISABLE, 32'hffff_ffff);
      `CHK("mask", 16'h1000, mask)
   endtask

   task automatic t_sof(input logic [10:0] n, input logic e);
      int k;
      @(posedge clk);
      idx  <= n;
      err  <= e;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      k = 0;
      while (sof.identifier !== 1'b1 && k < 10)
      begin
         @(posedge clk);
         k++;
      end
      if (k >= 10)
         fail_count++;
      #1;
      `CHK("irq", 1'b1, firq)
      `CHK("flags", 2'b00, {fval, ferr})
      @(posedge clk);
      #1;
      `CHK("irq", 1'b0, firq)
      k = 0;
      while (sof.packet_end !== 1'b1 && k < 10)
      begin
         @(posedge clk);
         k++;
      end
      if (k >= 10)
         fail_count++;
      #1;
      `CHK("frame", n, frame)
      `CHK("flags", {~e, e}, {fval, ferr})
      `CHK("low", {n[7:4], e, n[2:0]}, lo)
      `CHK("high", {~e, n[10:8]}, {hi[4], hi[2:0]})
      rdc(OFS_FRAME_STATUS, {14'h0, ~e, e, 5'h0, n});
   endtask

   task automatic t_state;
      wr(OFS_FUNC_ADDRESS, 32'h105);
      `CHK("addr", 7'h05, fad)
      wr(OFS_DEVICE_STATE, 32'h1);
      `CHK("astate", 1'b1, ast)
      wr(OFS_DEVICE_STATE, 32'h0);
      rdc(OFS_DEVICE_STATE, 32'h1);
      wr(OFS_DEVICE_STATE, 32'h3);
      rdc(OFS_DEVICE_STATE, 32'h3);
      wr(OFS_DEVICE_STATE, 32'h1);
      `CHK("config", 1'b0, cfg)
      wr(OFS_FUNC_ADDRESS, 32'h5);
      `CHK("fen", 1'b0, function_endpoint_enable)
      rdc(OFS_FUNC_ADDRESS, 32'h5);
      @(posedge clk);
      brst <= 1'b1;
      @(posedge clk);
      brst <= 1'b0;
      #1;
      `CHK("astate", 1'b0, ast)
      `CHK("mask", 16'h1200, mask)
      wr(OFS_FUNC_ADDRESS, 32'h105);
      `CHK("fen", 1'b1, function_endpoint_enable)
   endtask

   task automatic final_report;
      if (fail_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      fail_count  = 0;
      checks_done = 0;
      rst  = 1'b1;
      brst = 1'b0;
      send = 1'b0;
      err  = 1'b0;
      idx  = 11'h0;
      req  = '0;
      req.byteenable = 4'hf;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_mask();
      t_sof(11'h5a3, 1'b0);
      t_sof(11'h7ff, 1'b1);
      t_sof(11'h001, 1'b0);
      t_state();
      final_report();
   end

   initial
   begin
      repeat (5000) @(posedge clk);
      fail_count++;
      final_report();
   end
endmodule // usbsf_regs_test
